// ==== hw/pbs_pkg.sv ====
/*
  Shared constants for the port-B bus sizing logic: size modes, unit counts,
  almost-flag depth table and reset values.
  Assumes a single 100 MHz core clock with a synchronous active-high reset.
*/
package pbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int LONG_W  = 36;
  localparam int BYTE_W  = 9;
  localparam int WORD_W  = 18;
  localparam int CNT_W   = 2;
  localparam int THR_W   = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Size modes, encoded as {size_hi, size_lo}
  typedef enum logic [1:0] {
    PBS_LONG = 2'h0,
    PBS_WORD = 2'h1,
    PBS_BYTE = 2'h2,
    PBS_MBOX = 2'h3
  } pbs_mode_t;

  // Port transfers per long word
  localparam logic [CNT_W:0] UNITS_LONG = 3'h1;
  localparam logic [CNT_W:0] UNITS_WORD = 3'h2;
  localparam logic [CNT_W:0] UNITS_BYTE = 3'h4;

  // Lane positions
  localparam int TOP_BYTE_LSB = 27;
  localparam int TOP_WORD_LSB = 18;

  ////////////////////////////////////////////////////////////////////////////
  // Almost-flag depths in long words, picked by a 2-bit select at reset
  localparam logic [THR_W-1:0] DEPTH_0 = 5'h04;
  localparam logic [THR_W-1:0] DEPTH_1 = 5'h08;
  localparam logic [THR_W-1:0] DEPTH_2 = 5'h0c;
  localparam logic [THR_W-1:0] DEPTH_3 = 5'h10;

  // Inbound buffer depth in long words
  localparam int FIFO_DEPTH = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST  = 2'h0;
  localparam logic             SIZE_RST = 1'b0;
  localparam logic             BE_N_RST = 1'b0;

endpackage

// ==== hw/pbs_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides and a level output.
  Assumes one clock; the reader may stall, which fills it and drops in_ready.
*/
`timescale 1ns/1ns
module pbs_fifo #(
  parameter int W = 36,
  parameter int D = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D+1)-1:0]    level
);

  localparam int AW = $clog2(D);

  generate
    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
      $error("pbs_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [W-1:0]            mem [D];
  logic [AW-1:0]           wr_ptr_reg;
  logic [AW-1:0]           rd_ptr_reg;
  logic [$clog2(D+1)-1:0]  count_reg;
  logic                    push;
  logic                    pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes; full and empty straight from the count
  assign in_ready  = (count_reg != D[$clog2(D+1)-1:0]);
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr_reg];
  assign level     = count_reg;

  // Storage, no reset needed on the array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ==== hw/pbs_port_b.sv ====
/*
  Port-B bus sizing: splits outbound long words into byte/word reads,
  gathers byte/word writes into long words for the inbound buffer, and keeps
  port flags on long-word accounting.
  Assumes the outbound queue shows its head word and long-word count, and
  that all port inputs are synchronous to core_clk.
*/
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// How it works
// RL1 - Byte big-endian read: MS byte on top lane first, then the rest descending.
// RL2 - Whole output byte order is fixed when the long word is fetched.
// RL3 - Word little-endian read: low half first on low lanes, then high half.
// RL4 - Write data captured into two alternating register sets of four groups.
// RL5 - Registered size and endian steer lane and group placement.
// RL6 - One, two or four writes per long word; memory written on last.
// RL7 - Byte little-endian write uses lowest lane, LS byte first, fourth commits.
// RL8 - Almost-flag depth chosen from four presets during reset, in long words.
// RL9 - Almost flags compare the programmed depth in long words for any size.
// RL10 - Full flag waits until the final unit is in and memory written.
// RL11 - Empty flag held off while fetched word still has units to shift.
// RL12 - Size inputs registered each edge outside mailbox and applied the next cycle.
// RL13 - Outside mailbox, a size input differing from its register drives counter clear low.
// RL14 - The edge storing a new size clears the transfer counters.
// RL15 - Size change mid word drops unread data or the partial write.
// RL16 - Both size inputs high: mailbox, counters and size registers frozen.
// RL17 - Byte or word sizes drive only endian-selected lanes; others zero.
// RL18 - Read counter spans four byte or two word clocks, idle for long.
// RL19 - Size code 00 long, 01 word, 10 byte; endian low uses upper lanes.
// RL20 - Reset clears counters and size registers for a fresh long word.
module pbs_port_b #(
  parameter int OB_CW = 7
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic [1:0]                 flag_depth_sel,
  input  wire logic                       size_select_lo,
  input  wire logic                       size_select_hi,
  input  wire logic                       big_endian_select_n,
  input  wire logic                       rd_en,
  output logic [pbs_pkg::LONG_W-1:0]      b_dout,
  output logic                            b_dout_valid,
  input  wire logic                       wr_en,
  input  wire logic [pbs_pkg::LONG_W-1:0] b_din,
  input  wire logic [pbs_pkg::LONG_W-1:0] ob_data,
  input  wire logic [OB_CW-1:0]           ob_count,
  output logic                            ob_pop,
  output logic                            ib_valid,
  input  wire logic                       ib_ready,
  output logic [pbs_pkg::LONG_W-1:0]      ib_data,
  output logic                            port_b_empty_flag_n,
  output logic                            port_b_full_flag_n,
  output logic                            port_b_almost_empty_n,
  output logic                            port_b_almost_full_n,
  output logic                            transfer_counter_clear_n
);

  localparam int LW = pbs_pkg::LONG_W;
  localparam int CW = pbs_pkg::CNT_W;
  localparam int FD = pbs_pkg::FIFO_DEPTH;
  localparam int LV = $clog2(FD + 1);

  generate
    if (OB_CW < pbs_pkg::THR_W) begin : g_bad_cw
      $error("pbs_port_b outbound count too narrow for the flag depths");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Transfers per long word for a mode
  function automatic logic [CW:0] units_of(input pbs_pkg::pbs_mode_t md);
    case (md)
      pbs_pkg::PBS_BYTE: units_of = pbs_pkg::UNITS_BYTE;
      pbs_pkg::PBS_WORD: units_of = pbs_pkg::UNITS_WORD;
      default:           units_of = pbs_pkg::UNITS_LONG;
    endcase
  endfunction

  // Put unit idx of a long word on its lanes; other lanes read zero
  function automatic logic [LW-1:0] place(input logic [LW-1:0] w,
                                          input logic [CW-1:0] idx,
                                          input pbs_pkg::pbs_mode_t md,
                                          input logic be_n);
    logic [LW-1:0] r;
    logic [LW-1:0] t;
    logic [CW-1:0] u;
    r = '0;
    t = '0;
    u = '0;
    case (md)
      pbs_pkg::PBS_BYTE: begin
        u = be_n ? idx : 2'h3 - idx;
        t = w >> (6'(u) * 6'h09);
        if (be_n) begin
          r[pbs_pkg::BYTE_W-1:0] = t[pbs_pkg::BYTE_W-1:0];
        end else begin
          r[LW-1:pbs_pkg::TOP_BYTE_LSB] = t[pbs_pkg::BYTE_W-1:0];
        end
      end
      pbs_pkg::PBS_WORD: begin
        u = {1'b0, be_n ? idx[0] : ~idx[0]};
        t = w >> (6'(u) * 6'h12);
        if (be_n) begin
          r[pbs_pkg::WORD_W-1:0] = t[pbs_pkg::WORD_W-1:0];
        end else begin
          r[LW-1:pbs_pkg::TOP_WORD_LSB] = t[pbs_pkg::WORD_W-1:0];
        end
      end
      default: r = w;
    endcase
    return r;
  endfunction

  // Drop one incoming unit into its group of the gathering word
  function automatic logic [LW-1:0] gather(input logic [LW-1:0] acc,
                                           input logic [LW-1:0] din,
                                           input logic [CW-1:0] idx,
                                           input pbs_pkg::pbs_mode_t md,
                                           input logic be_n);
    logic [LW-1:0] m;
    logic [LW-1:0] v;
    logic [5:0]    sh;
    m  = '0;
    v  = '0;
    sh = '0;
    case (md)
      pbs_pkg::PBS_BYTE: begin
        sh = 6'(be_n ? idx : 2'h3 - idx) * 6'h09;
        m  = 36'h0001ff << sh;
        v  = 36'(be_n ? din[8:0] : din[35:27]) << sh;
      end
      pbs_pkg::PBS_WORD: begin
        sh = (be_n ? idx[0] : ~idx[0]) ? 6'h12 : 6'h00;
        m  = 36'h03ffff << sh;
        v  = 36'(be_n ? din[17:0] : din[35:18]) << sh;
      end
      default: begin
        m = '1;
        v = din;
      end
    endcase
    return (acc & ~m) | v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Size control

  logic               size_reg_lo;
  logic               size_reg_hi;
  logic               be_n_reg;
  logic               size_compare_lo;
  logic               size_compare_hi;
  logic               mbox_in;
  logic               clr_n;
  pbs_pkg::pbs_mode_t mode_cur;
  logic [CW:0]        n_units;

  // Mailbox code is never taken for a size change
  assign size_compare_lo = size_select_lo ~^ size_reg_lo;              // [RL13]
  assign size_compare_hi = size_select_hi ~^ size_reg_hi;              // [RL13]
  assign mbox_in         = size_select_lo & size_select_hi;            // [RL16]
  assign clr_n           = mbox_in | (size_compare_lo & size_compare_hi); // [RL13]
  assign mode_cur        = pbs_pkg::pbs_mode_t'({size_reg_hi, size_reg_lo}); // [RL19]
  assign n_units         = units_of(mode_cur);

  // Size registers; frozen while mailbox is selected
  always_ff @(posedge core_clk) begin
    if (rst) begin
      size_reg_lo <= pbs_pkg::SIZE_RST;                                // [RL20]
      size_reg_hi <= pbs_pkg::SIZE_RST;
      be_n_reg    <= pbs_pkg::BE_N_RST;
    end else if (!mbox_in) begin
      size_reg_lo <= size_select_lo;                                   // [RL12]
      size_reg_hi <= size_select_hi;                                   // [RL12]
      be_n_reg    <= big_endian_select_n;                              // [RL5]
    end
  end

  // Clear pulse shown on a port, registered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      transfer_counter_clear_n <= 1'b1;
    end else begin
      transfer_counter_clear_n <= clr_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Almost-flag depth, sampled while reset is held

  logic [pbs_pkg::THR_W-1:0] thr_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      case (flag_depth_sel)                                            // [RL8]
        2'h0:    thr_reg <= pbs_pkg::DEPTH_0;
        2'h1:    thr_reg <= pbs_pkg::DEPTH_1;
        2'h2:    thr_reg <= pbs_pkg::DEPTH_2;
        default: thr_reg <= pbs_pkg::DEPTH_3;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [CW-1:0]    rd_cnt_reg;
  logic [CW-1:0]    rd_cnt_next;
  logic [LW-1:0]    rd_word_reg;
  logic             rd_be_n_reg;
  logic             rd_take;
  logic             rd_last;
  logic [OB_CW-1:0] ob_after;

  // A fetch needs a word waiting; a shift needs only the pipeline
  assign rd_take = rd_en & port_b_empty_flag_n & clr_n & ~mbox_in
                 & ((rd_cnt_reg != '0) | (ob_count != '0));
  assign ob_pop  = rd_take & (rd_cnt_reg == '0);                       // [RL18]
  assign rd_last = ({1'b0, rd_cnt_reg} == n_units - 1'b1);
  assign ob_after = ob_count - OB_CW'(ob_pop);

  // Counter: clear wins, long mode never leaves zero
  always_comb begin
    rd_cnt_next = rd_cnt_reg;
    if (!clr_n) begin
      rd_cnt_next = pbs_pkg::CNT_RST;                                  // [RL14] [RL15]
    end else if (rd_take) begin
      rd_cnt_next = rd_last ? pbs_pkg::CNT_RST : rd_cnt_reg + 1'b1;    // [RL18]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_cnt_reg <= pbs_pkg::CNT_RST;                                  // [RL20]
    end else begin
      rd_cnt_reg <= rd_cnt_next;
    end
  end

  // Word and its endian held for the whole long word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_word_reg <= '0;
      rd_be_n_reg <= pbs_pkg::BE_N_RST;
    end else if (ob_pop) begin
      rd_word_reg <= ob_data;                                          // [RL2]
      rd_be_n_reg <= be_n_reg;                                         // [RL2]
    end
  end

  // Output lanes; first unit comes from the fetch, rest from the held word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      b_dout       <= '0;
      b_dout_valid <= 1'b0;
    end else begin
      b_dout_valid <= rd_take;
      if (ob_pop) begin
        b_dout <= place(ob_data, rd_cnt_reg, mode_cur, be_n_reg);      // [RL1] [RL3] [RL17]
      end else if (rd_take) begin
        b_dout <= place(rd_word_reg, rd_cnt_reg, mode_cur, rd_be_n_reg); // [RL1] [RL3]
      end
    end
  end

  // Empty held off while units remain; almost empty on long words
  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_b_empty_flag_n   <= 1'b0;
      port_b_almost_empty_n <= 1'b0;
    end else begin
      port_b_empty_flag_n   <= (rd_cnt_next != '0) | (ob_after != '0); // [RL11]
      port_b_almost_empty_n <= (ob_after > OB_CW'(thr_reg));           // [RL9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write path

  logic [CW-1:0] wr_cnt_reg;
  logic [LW-1:0] wr_set_reg [2];
  logic          wr_bank_reg;
  logic          wr_take;
  logic          wr_last;
  logic [LW-1:0] wr_word;
  logic          fifo_in_ready;
  logic          ib_push;
  logic [LV-1:0] ib_level;
  logic [LV-1:0] ib_after;

  // Final unit waits for buffer room, so nothing is lost on back-pressure
  assign wr_last = ({1'b0, wr_cnt_reg} == n_units - 1'b1);
  assign wr_take = wr_en & port_b_full_flag_n & clr_n & ~mbox_in
                 & (~wr_last | fifo_in_ready);
  assign wr_word = gather(wr_set_reg[wr_bank_reg], b_din, wr_cnt_reg,
                          mode_cur, be_n_reg);                         // [RL5] [RL7]
  assign ib_push = wr_take & wr_last;                                  // [RL6]

  // Unit counter; a size change drops the partial word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_cnt_reg <= pbs_pkg::CNT_RST;                                  // [RL20]
    end else if (!clr_n) begin
      wr_cnt_reg <= pbs_pkg::CNT_RST;                                  // [RL14] [RL15]
    end else if (wr_take) begin
      wr_cnt_reg <= wr_last ? pbs_pkg::CNT_RST : wr_cnt_reg + 1'b1;    // [RL6]
    end
  end

  // Two input sets, swapped after each committed long word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_set_reg[0] <= '0;
      wr_set_reg[1] <= '0;
      wr_bank_reg   <= 1'b0;
    end else if (wr_take) begin
      wr_set_reg[wr_bank_reg] <= wr_word;                              // [RL4]
      if (wr_last) begin
        wr_bank_reg <= ~wr_bank_reg;                                   // [RL4]
      end
    end
  end

  // Inbound buffer between gathering and the inbound queue
  pbs_fifo #(
    .W (LW),
    .D (FD)
  ) u_inbound_buf (
    .clk       (core_clk),
    .rst       (rst),
    .in_valid  (ib_push),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_word),
    .out_valid (ib_valid),
    .out_ready (ib_ready),
    .out_data  (ib_data),
    .level     (ib_level)
  );

  assign ib_after = ib_level + LV'(ib_push) - LV'(ib_valid & ib_ready);

  // Full only once the last long word is really stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_b_full_flag_n   <= 1'b1;
      port_b_almost_full_n <= 1'b1;
    end else begin
      port_b_full_flag_n   <= (ib_after != LV'(FD));                   // [RL10]
      port_b_almost_full_n <= (LV'(FD) - ib_after) > LV'(thr_reg);     // [RL9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_byte_big_first;
    @(posedge core_clk) disable iff (rst)
      (ob_pop && mode_cur == pbs_pkg::PBS_BYTE && !be_n_reg)
      |=> (b_dout[35:27] == $past(ob_data[35:27])) && (b_dout[26:0] == '0);
  endproperty
  a_byte_big_first: assert property (p_byte_big_first) // [RL1]
    else $error("byte big-endian first byte wrong");

  property p_word_little_first;
    @(posedge core_clk) disable iff (rst)
      (ob_pop && mode_cur == pbs_pkg::PBS_WORD && be_n_reg)
      |=> (b_dout[17:0] == $past(ob_data[17:0])) && (b_dout[35:18] == '0);
  endproperty
  a_word_little_first: assert property (p_word_little_first) // [RL3]
    else $error("word little-endian first half wrong");

  property p_no_fetch_busy;
    @(posedge core_clk) disable iff (rst)
      (rd_cnt_reg != '0) |-> !ob_pop;
  endproperty
  a_no_fetch_busy: assert property (p_no_fetch_busy) // [RL18]
    else $error("memory read while pipeline busy");

  property p_push_last;
    @(posedge core_clk) disable iff (rst)
      ib_push |-> ({1'b0, wr_cnt_reg} == n_units - 1'b1) && clr_n;
  endproperty
  a_push_last: assert property (p_push_last) // [RL6]
    else $error("long word written before last unit");

  property p_change_clears;
    @(posedge core_clk) disable iff (rst)
      (!mbox_in && (size_select_lo != size_reg_lo))
      |=> (rd_cnt_reg == '0) && (wr_cnt_reg == '0) && !$past(ib_push);
  endproperty
  a_change_clears: assert property (p_change_clears) // [RL14]
    else $error("size change did not clear counters");

  property p_mbox_freeze;
    @(posedge core_clk) disable iff (rst)
      mbox_in |=> $stable(size_reg_lo) && $stable(size_reg_hi)
                  && $stable(rd_cnt_reg) && $stable(wr_cnt_reg);
  endproperty
  a_mbox_freeze: assert property (p_mbox_freeze) // [RL16]
    else $error("mailbox disturbed size state");

  property p_empty_held;
    @(posedge core_clk) disable iff (rst)
      (rd_cnt_reg != '0) |-> port_b_empty_flag_n;
  endproperty
  a_empty_held: assert property (p_empty_held) // [RL11]
    else $error("empty asserted with units pending");

  property p_size_latency;
    @(posedge core_clk) disable iff (rst)
      !mbox_in |=> (size_reg_lo == $past(size_select_lo))
                   && (size_reg_hi == $past(size_select_hi));
  endproperty
  a_size_latency: assert property (p_size_latency) // [RL12]
    else $error("size not registered on the edge");

endmodule

// ==== tb/pbs_ob_model.sv ====
/*
  Outbound long-word queue model that feeds the port-B read path.
  Assumes ob_pop is a one-cycle pulse sampled at the core_clk edge.
*/
`timescale 1ns/1ns
module pbs_ob_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        push,
  input  wire logic [35:0] push_data,
  input  wire logic        ob_pop,
  output logic [35:0]      ob_data,
  output logic [6:0]       ob_count
);
  logic [35:0] q[$];

  // Queue update; an empty queue shows a toggling word, never a stale head
  always @(posedge core_clk) begin
    if (rst) begin
      q.delete();
    end else begin
      if (ob_pop && q.size() > 0) void'(q.pop_front());
      if (push) q.push_back(push_data);
    end
    ob_count <= 7'(q.size());
    ob_data <= (q.size() > 0) ? q[0] : (rst ? 36'h0 : ~ob_data);
  end
endmodule

// ==== tb/pbs_port_b_tb.sv ====
/*
  Self-checking bench for the port-B sizing block: reads, writes, size changes.
  Assumes the outbound queue model and a free-running 100 MHz core_clk.
*/
`timescale 1ns/1ns
module pbs_port_b_tb;
  logic core_clk = 1'b0, rst = 1'b1, lo = 1'b0, hi = 1'b0, ben = 1'b0;
  logic rd_en = 1'b0, wr_en = 1'b0, ib_ready = 1'b0, push = 1'b0;
  logic [1:0] dsel = 2'h0;
  logic [35:0] b_din = 36'h0, push_data = 36'h0, ob_data, b_dout, ib_data;
  logic [6:0]  ob_count;
  logic ob_pop, b_dout_valid, ib_valid, empty_n, full_n, ae_n, af_n, clr_n;
  int n_fail = 0, compares = 0;
  pbs_pkg::pbs_mode_t cm = pbs_pkg::PBS_LONG;

  always #5 core_clk = ~core_clk;

  pbs_port_b uut (.core_clk(core_clk), .rst(rst), .flag_depth_sel(dsel),
    .size_select_lo(lo), .size_select_hi(hi), .big_endian_select_n(ben),
    .rd_en(rd_en), .b_dout(b_dout), .b_dout_valid(b_dout_valid), .wr_en(wr_en),
    .b_din(b_din), .ob_data(ob_data), .ob_count(ob_count), .ob_pop(ob_pop),
    .ib_valid(ib_valid), .ib_ready(ib_ready), .ib_data(ib_data),
    .port_b_empty_flag_n(empty_n), .port_b_full_flag_n(full_n),
    .port_b_almost_empty_n(ae_n), .port_b_almost_full_n(af_n),
    .transfer_counter_clear_n(clr_n));

  pbs_ob_model obq (.core_clk(core_clk), .rst(rst), .push(push),
    .push_data(push_data), .ob_pop(ob_pop), .ob_data(ob_data), .ob_count(ob_count));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic final_report();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(logic [35:0] got, logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic int units(pbs_pkg::pbs_mode_t m);
    return (m == pbs_pkg::PBS_BYTE) ? 4 : (m == pbs_pkg::PBS_WORD) ? 2 : 1;
  endfunction

  // Unit k of a long word, placed on its endian lanes, other lanes zero
  function automatic logic [35:0] unit_of(logic [35:0] w, int n, logic be_n, int k);
    int uw;
    logic [35:0] msk;
    uw = 36 / n;
    msk = (n == 1) ? {36{1'b1}} : ((36'h1 << uw) - 36'h1);
    return ((w >> (be_n ? uw * k : 36 - uw * (k + 1))) & msk) << (be_n ? 0 : 36 - uw);
  endfunction

  // Size change clears counters for one cycle; endian alone does not
  task automatic set_mode(pbs_pkg::pbs_mode_t m, logic be_n);
    @(posedge core_clk);
    {hi, lo} <= m;
    ben <= be_n;
    @(posedge core_clk);
    #1 chk(clr_n, m == cm);
    cm = m;
  endtask

  task automatic do_read(logic [35:0] w);
    int t, n;
    n = units(cm);
    @(posedge core_clk);
    push <= 1'b1;
    push_data <= w;
    @(posedge core_clk);
    push <= 1'b0;
    // Flag looked at 1 ns after the edge that launches it
    #1;
    for (t = 0; t < 20 && empty_n !== 1'b1; t++) begin
      @(posedge core_clk);
      #1;
    end
    if (t == 20) begin
      n_fail++;
      final_report();
    end
    @(posedge core_clk);
    rd_en <= 1'b1;
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      if (k == n - 1) rd_en <= 1'b0;
      #1 chk(b_dout, unit_of(w, n, ben, k));
      chk(b_dout_valid, 1'b1);
      if (k < n - 1) chk(empty_n, 1'b1);
    end
  endtask

  // Writes c units of w; unselected lanes carry random junk
  task automatic do_write(logic [35:0] w, int c);
    int n;
    n = units(cm);
    for (int k = 0; k <= c; k++) begin
      @(posedge core_clk);
      wr_en <= (k < c);
      b_din <= unit_of(w, n, ben, k % n) | (~unit_of({36{1'b1}}, n, ben, k % n) &
               36'({$urandom(), $urandom()}));
      if (k > 0) #1 chk(ib_valid, k == n);
    end
    if (c == n) begin
      chk(ib_data, w);
      @(posedge core_clk);
      ib_ready <= 1'b1;
      @(posedge core_clk);
      ib_ready <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    pbs_pkg::pbs_mode_t m;
    logic b;
    int thr;
    void'($urandom(32'hd837));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1 chk(clr_n, 1'b1);
    chk({empty_n, full_n, ae_n, af_n}, 36'h5);
    // Corner cases: byte big-endian and word little-endian reads, byte little-endian write, fixed patterns
    set_mode(pbs_pkg::PBS_BYTE, 1'b0);
    do_read(36'h9_8765_4321);
    set_mode(pbs_pkg::PBS_WORD, 1'b1);
    do_read(36'hf_0f0f_1e1e);
    set_mode(pbs_pkg::PBS_BYTE, 1'b1);
    do_write(36'h1_2345_6789, 4);
    // Partial write dropped by a size change
    do_write(36'ha_aaaa_aaaa, 2);
    set_mode(pbs_pkg::PBS_LONG, 1'b0);
    do_write(36'h5_5555_5555, 1);
    // Mailbox code leaves size and counters alone
    @(posedge core_clk);
    {hi, lo} <= pbs_pkg::PBS_MBOX;
    @(posedge core_clk);
    #1 chk(clr_n, 1'b1);
    set_mode(pbs_pkg::PBS_LONG, 1'b0);
    // Flags on long words for two depths, each after a fresh mid-run reset
    for (int d = 0; d < 2; d++) begin
      thr = (d == 0) ? int'(pbs_pkg::DEPTH_0) : int'(pbs_pkg::DEPTH_1);
      @(posedge core_clk);
      rst <= 1'b1;
      dsel <= 2'(d);
      {hi, lo} <= 2'h0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      cm = pbs_pkg::PBS_LONG;
      @(posedge core_clk);
      #1 chk({empty_n, full_n, ae_n, af_n, clr_n}, 36'hb);
      // Five long words queued outbound, then read back one per clock
      for (int i = 0; i <= 5; i++) begin
        @(posedge core_clk);
        push <= (i < 5);
        push_data <= 36'(i + 1);
      end
      @(posedge core_clk);
      #1 chk(ae_n, 5 > thr);
      @(posedge core_clk);
      rd_en <= 1'b1;
      for (int i = 0; i < 5; i++) begin
        @(posedge core_clk);
        if (i == 4) rd_en <= 1'b0;
        #1 chk(b_dout, 36'(i + 1));
        chk(ae_n, 4 - i > thr);
      end
      // Fill the inbound buffer with ready held low, then drain it
      for (int i = 0; i <= 16; i++) begin
        @(posedge core_clk);
        wr_en <= (i < 16);
        b_din <= 36'(i);
        if (i > 0) #1 chk({full_n, af_n}, {i < 16, 16 - i > thr});
      end
      @(posedge core_clk);
      ib_ready <= 1'b1;
      for (int i = 0; i < 16; i++) begin
        #1 chk(ib_data, 36'(i));
        @(posedge core_clk);
      end
      ib_ready <= 1'b0;
    end
    // Random sizes, endians and data
    for (int i = 0; i < 12; i++) begin
      m = pbs_pkg::pbs_mode_t'($urandom_range(2, 0));
      b = 1'($urandom());
      set_mode(m, b);
      do_read(36'({$urandom(), $urandom()}));
      do_write(36'({$urandom(), $urandom()}), units(m));
    end
    final_report();
  end
endmodule
